// *** tb/pldp_bus_model.sv ***
// firmware or dma side: register, fifo and config writes
`default_nettype none
module pldp_bus_model (
   // clock
   input  wire logic        ref_clk,
   // register and fifo bus
   output var  logic        bus_wr,
   output var  logic [2:0]  bus_sel,
   output var  logic [7:0]  bus_wdata,
   output var  logic        bus_rd_fifo0,
   output var  logic        bus_rd_fifo1,
   // configuration memory
   output var  logic        cfg_wr,
   output var  logic [2:0]  cfg_wr_addr,
   output var  logic [15:0] cfg_wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {bus_wr, bus_rd_fifo0, bus_rd_fifo1, cfg_wr} = 4'h0;
      {bus_sel, cfg_wr_addr} = 6'h00;
      bus_wdata = 8'h00;
      cfg_wr_data = 16'h0000;
   end
   task automatic write_reg(input logic [2:0] sel, input logic [7:0] data);
      @(posedge ref_clk);
      bus_wr <= 1'b1;
      bus_sel <= sel;
      bus_wdata <= data;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
      // stale data inverted so it never passes for valid
      bus_wdata <= ~data;
   endtask
   task automatic pop(input logic which);
      @(posedge ref_clk);
      bus_rd_fifo0 <= !which;
      bus_rd_fifo1 <= which;
      @(posedge ref_clk);
      bus_rd_fifo0 <= 1'b0;
      bus_rd_fifo1 <= 1'b0;
   endtask
   task automatic cfg_write(input logic [2:0] addr, input logic [15:0] word);
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_wr_addr <= addr;
      cfg_wr_data <= word;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      cfg_wr_data <= ~word;
   endtask
endmodule
`default_nettype wire

// *** tb/pldp_datapath_sva.sv ***
// port-level assertion checker for the datapath slice
`default_nettype none
module pldp_datapath_sva (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst_n,
   // bus writes
   input wire logic       bus_wr,
   input wire logic [2:0] bus_sel,
   input wire logic [7:0] bus_wdata,
   // register views
   input wire logic [7:0] accumulator_zero_ff,
   input wire logic [7:0] accumulator_one_ff,
   input wire logic [7:0] data_reg_zero_ff,
   input wire logic [7:0] data_reg_one_ff,
   // condition flags
   input wire logic       carry_ff,
   input wire logic       zero_det0_ff,
   input wire logic       ff_det1_ff,
   input wire logic       eq_cmp0_ff,
   input wire logic       lt_cmp1_ff,
   // fifo status
   input wire logic       fifo_zero_full_ff,
   input wire logic       fifo_zero_empty_ff,
   input wire logic       fifo_one_full_ff,
   input wire logic       fifo_one_empty_ff
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ----
   // fifo status
   // ----
   a_fifo0_status_excl: assert property (!(fifo_zero_full_ff && fifo_zero_empty_ff))
      else $error("fifo0 full and empty together");
   a_fifo1_status_excl: assert property (!(fifo_one_full_ff && fifo_one_empty_ff))
      else $error("fifo1 full and empty together");

   // ----
   // flags trail the registers by one edge
   // ----
   a_zero_det_acc0: assert property ($past(rst_n) |-> zero_det0_ff == ($past(accumulator_zero_ff) == 8'h00))
      else $error("zero detect on acc0 wrong");
   a_ones_det_acc1: assert property ($past(rst_n) |-> ff_det1_ff == ($past(accumulator_one_ff) == 8'hff))
      else $error("all-ones detect on acc1 wrong");
   a_equal_cmp_zero: assert property ($past(rst_n) |->
      eq_cmp0_ff == ($past(accumulator_zero_ff) == $past(data_reg_zero_ff)))
      else $error("equal compare acc0 dat0 wrong");
   a_less_cmp_one: assert property ($past(rst_n) |->
      lt_cmp1_ff == ($past(accumulator_one_ff) < $past(data_reg_one_ff)))
      else $error("less compare acc1 dat1 wrong");

   // ----
   // bus writes win over every other source
   // ----
   a_bus_acc0_write: assert property (bus_wr && bus_sel == 3'h0 |=> accumulator_zero_ff == $past(bus_wdata))
      else $error("bus write to acc0 lost");
   a_bus_dat1_write: assert property (bus_wr && bus_sel == 3'h3 |=> data_reg_one_ff == $past(bus_wdata))
      else $error("bus write to dat1 lost");

   c_equal_seen: cover property (eq_cmp0_ff);
   c_fifo_full: cover property (fifo_zero_full_ff);
   c_carry_out: cover property (carry_ff);
endmodule
`default_nettype wire

// *** tb/pldp_datapath_test.sv ***
// self-checking bench for the datapath slice
`default_nettype none
module pldp_datapath_test
   import pldp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  seq_addr = 3'h0;
   logic        bus_wr, bus_rd_fifo0, bus_rd_fifo1, cfg_wr, car_v;
   logic [2:0]  bus_sel, cfg_wr_addr;
   logic [7:0]  bus_wdata, alu_v, alu_out_ff, fifo_zero_head_ff, fifo_one_head_ff;
   logic [15:0] cfg_wr_data;
   logic [7:0]  accumulator_zero_ff, accumulator_one_ff, data_reg_zero_ff, data_reg_one_ff;
   logic        carry_ff, zero_det0_ff, zero_det1_ff, ff_det0_ff, ff_det1_ff;
   logic        eq_cmp0_ff, lt_cmp0_ff, eq_cmp1_ff, lt_cmp1_ff;
   logic        fifo_zero_full_ff, fifo_zero_empty_ff, fifo_one_full_ff, fifo_one_empty_ff;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;

   always #50 ref_clk = ~ref_clk;

   pldp_datapath u_pldp_datapath (.ref_clk, .rst_n, .seq_addr, .cfg_wr, .cfg_wr_addr, .cfg_wr_data,
      .bus_wr, .bus_sel, .bus_wdata, .bus_rd_fifo0, .bus_rd_fifo1, .accumulator_zero_ff,
      .accumulator_one_ff, .data_reg_zero_ff, .data_reg_one_ff, .fifo_zero_head_ff, .fifo_one_head_ff,
      .alu_out_ff, .carry_ff, .zero_det0_ff, .zero_det1_ff, .ff_det0_ff, .ff_det1_ff, .eq_cmp0_ff,
      .lt_cmp0_ff, .eq_cmp1_ff, .lt_cmp1_ff, .fifo_zero_full_ff, .fifo_zero_empty_ff, .fifo_one_full_ff,
      .fifo_one_empty_ff);
   pldp_bus_model u_pldp_bus_model (.ref_clk, .bus_wr, .bus_sel, .bus_wdata, .bus_rd_fifo0,
      .bus_rd_fifo1, .cfg_wr, .cfg_wr_addr, .cfg_wr_data);

   // ----
   // checking and closing
   // ----
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end

   // ----
   // helpers
   // ----
   function automatic logic [15:0] cw(input logic [2:0] op, input logic [1:0] sa, sb, dst, f0wr, f1wr,
                                      input logic f0ld, f1ld, prio);
      return {prio, f1wr, f0wr, f1ld, f0ld, dst, sb, sa, op};
   endfunction
   // carry and result of op k on acc0 c5, acc1 7a
   logic [8:0] alu_e [8] = '{9'h0c5, 9'h0c6, 9'h0c4, 9'h13f, 9'h04b, 9'h040, 9'h0ff, 9'h0bf};
   // one cycle of word k, then back to the idle word 0
   task automatic run_cfg(input logic [2:0] k);
      @(posedge ref_clk);
      seq_addr <= k;
      @(posedge ref_clk);
      seq_addr <= 3'h0;
      @(posedge ref_clk);
      #1;
      alu_v = alu_out_ff;
      car_v = carry_ff;
      @(posedge ref_clk);
      #1;
   endtask

   // ----
   // scenarios
   // ----
   task automatic t_reset();
      check(accumulator_zero_ff, 8'h00);
      check(fifo_zero_empty_ff, 1'b1);
      check(fifo_one_full_ff, 1'b0);
   endtask
   task automatic t_alu_ops();
      u_pldp_bus_model.write_reg(3'h0, 8'hc5);
      u_pldp_bus_model.write_reg(3'h1, 8'h7a);
      for (int k = 1; k < 8; k++)
         u_pldp_bus_model.cfg_write(3'(k), cw(3'(k), 2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
      for (int k = 0; k < 8; k++) begin
         run_cfg(3'(k));
         check(alu_v, alu_e[k][7:0]);
         if (k inside {[1:4]})
            check(car_v, alu_e[k][8]);
      end
      check(accumulator_zero_ff, 8'hc5);
   endtask
   task automatic t_dest_cmp();
      u_pldp_bus_model.write_reg(3'h2, 8'hc5);
      u_pldp_bus_model.cfg_write(3'h1, cw(3'h3, 2'h0, 2'h2, 2'h2, 2'h0, 2'h0, 1'b0, 1'b0, 1'b0));
      run_cfg(3'h1);
      check(accumulator_one_ff, 8'h8a);
      check(data_reg_zero_ff, 8'hc5);
      check(eq_cmp0_ff, 1'b1);
      u_pldp_bus_model.write_reg(3'h3, 8'h8b);
      @(posedge ref_clk);
      #1;
      check(lt_cmp1_ff, 1'b1);
      check(zero_det1_ff, 1'b0);
      check(eq_cmp1_ff, 1'b0);
      check(lt_cmp0_ff, 1'b0);
      check(ff_det0_ff, 1'b0);
   endtask
   // fifth push must be dropped, order kept on drain
   task automatic t_fifo_fill();
      for (int i = 0; i < 5; i++)
         u_pldp_bus_model.write_reg(3'h4, 8'h11 + 8'(i));
      @(posedge ref_clk);
      #1;
      check(fifo_zero_full_ff, 1'b1);
      for (int i = 0; i < 4; i++) begin
         check(fifo_zero_head_ff, 8'h11 + 8'(i));
         u_pldp_bus_model.pop(1'b0);
         @(posedge ref_clk);
         #1;
      end
      check(fifo_zero_empty_ff, 1'b1);
   endtask
   task automatic t_fifo_route();
      u_pldp_bus_model.write_reg(3'h5, 8'h3c);
      u_pldp_bus_model.cfg_write(3'h2, cw(3'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b1, 1'b1));
      u_pldp_bus_model.cfg_write(3'h3, cw(3'h7, 2'h0, 2'h1, 2'h0, 2'h3, 2'h1, 1'b0, 1'b0, 1'b0));
      check(fifo_one_head_ff, 8'h3c);
      run_cfg(3'h2);
      check(data_reg_one_ff, 8'h3c);
      check(fifo_one_empty_ff, 1'b1);
      run_cfg(3'h3);
      check(fifo_zero_head_ff, 8'hc5 ^ 8'h8a);
      check(fifo_zero_empty_ff, 1'b0);
      check(fifo_one_head_ff, 8'hc5);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      t_reset();
      t_alu_ops();
      t_dest_cmp();
      t_fifo_fill();
      t_fifo_route();
      report_and_stop();
   end
endmodule

bind pldp_datapath pldp_datapath_sva u_pldp_datapath_sva (.ref_clk, .rst_n, .bus_wr, .bus_sel, .bus_wdata,
   .accumulator_zero_ff, .accumulator_one_ff, .data_reg_zero_ff, .data_reg_one_ff, .carry_ff,
   .zero_det0_ff, .ff_det1_ff, .eq_cmp0_ff, .lt_cmp1_ff, .fifo_zero_full_ff, .fifo_zero_empty_ff,
   .fifo_one_full_ff, .fifo_one_empty_ff);
`default_nettype wire

// *** verilog/pldp_cfg_ram.sv ***
// configuration memory of the datapath, registered read
`default_nettype none
module pldp_cfg_ram
   import pldp_pkg::*;
#(
   parameter int WORDS = 8,
   parameter int WIDTH = 16,
   parameter int AW    = 3
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // write port
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   // read port
   input  wire logic [AW-1:0]    rd_addr,
   output var  logic [WIDTH-1:0] rd_data_ff
);
   `include "pldp_defines.svh"

   initial begin
      if (WORDS != (1 << AW)) begin
         $error("pldp_cfg_ram: WORDS must equal 2**AW");
      end
   end

   logic [WIDTH-1:0] mem_ff [WORDS];

   // ---------------------------------------------------------------
   // storage, reset to all-pass configuration
   // ---------------------------------------------------------------
   for (genvar i = 0; i < WORDS; i++) begin : g_word
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            mem_ff[i] <= `PLDP_RST_CFG;
         end else if (wr_en && (wr_addr == AW'(i))) begin
            mem_ff[i] <= wr_data;
         end
      end
   end

   // registered read: address given now drives next cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff <= `PLDP_RST_CFG;
      end else begin
         rd_data_ff <= mem_ff[rd_addr];
      end
   end
endmodule
`default_nettype wire

// *** verilog/pldp_datapath.sv ***
// programmable 8-bit datapath slice with configuration memory and fifos
// Function
// - single-cycle ALU on 8-bit operands.
// - compare and condition logic give status outputs from registers.
// - six working registers, each reachable by firmware or DMA.
// - accumulators are ALU sources, result sinks and compare inputs.
// - data registers are ALU sources and compare inputs, never ALU results.
// - two four-byte fifos load registers or capture accumulators or ALU output.
// - datapath function changes every clock under sequencer control.
// - eight-word by 16-bit memory holds eight selectable configurations.
// - sequencer address picks the active configuration every cycle.
// - ALU does increment, decrement, add, subtract, and, or, xor, pass.
// - pass forwards an operand unchanged to an accumulator or fifo.
`default_nettype none
module pldp_datapath
   import pldp_pkg::*;
#(
   parameter int WIDTH      = 8,
   parameter int CFG_WORDS  = 8,
   parameter int CFG_WIDTH  = 16,
   parameter int FIFO_DEPTH = 4
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // sequencer from the routing matrix
   input  wire logic [2:0]       seq_addr,
   // configuration memory programming
   input  wire logic             cfg_wr,
   input  wire logic [2:0]       cfg_wr_addr,
   input  wire logic [CFG_WIDTH-1:0] cfg_wr_data,
   // firmware or dma direct register writes
   input  wire logic             bus_wr,
   input  wire logic [2:0]       bus_sel,
   input  wire logic [WIDTH-1:0] bus_wdata,
   // firmware or dma fifo reads
   input  wire logic             bus_rd_fifo0,
   input  wire logic             bus_rd_fifo1,
   // working register views
   output logic [WIDTH-1:0]      accumulator_zero_ff,
   output logic [WIDTH-1:0]      accumulator_one_ff,
   output logic [WIDTH-1:0]      data_reg_zero_ff,
   output logic [WIDTH-1:0]      data_reg_one_ff,
   output logic [WIDTH-1:0]      fifo_zero_head_ff,
   output logic [WIDTH-1:0]      fifo_one_head_ff,
   // alu and condition outputs
   output logic [WIDTH-1:0]      alu_out_ff,
   output logic                  carry_ff,
   output logic                  zero_det0_ff,
   output logic                  zero_det1_ff,
   output logic                  ff_det0_ff,
   output logic                  ff_det1_ff,
   output logic                  eq_cmp0_ff,
   output logic                  lt_cmp0_ff,
   output logic                  eq_cmp1_ff,
   output logic                  lt_cmp1_ff,
   // fifo status
   output logic                  fifo_zero_full_ff,
   output logic                  fifo_zero_empty_ff,
   output logic                  fifo_one_full_ff,
   output logic                  fifo_one_empty_ff
);
   `include "pldp_defines.svh"

   initial begin
      if (WIDTH != 8 || CFG_WIDTH != 16 || CFG_WORDS != 8) begin
         $error("pldp_datapath: configuration layout needs 8-bit data, 8 x 16-bit words");
      end
   end

   // ---------------------------------------------------------------
   // configuration memory
   // ---------------------------------------------------------------
   // bus_sel codes: 0 acc0, 1 acc1, 2 dat0, 3 dat1, 4 fifo0 push, 5 fifo1 push
   logic [CFG_WIDTH-1:0] cfg;

   // the registered read costs a cycle of latency but keeps the path short
   pldp_cfg_ram #(
      .WORDS (CFG_WORDS),
      .WIDTH (CFG_WIDTH),
      .AW    (3)
   ) u_cfg_ram (
      .ref_clk    (ref_clk),
      .rst_n      (rst_n),
      .wr_en      (cfg_wr),
      .wr_addr    (cfg_wr_addr),
      .wr_data    (cfg_wr_data),
      .rd_addr    (seq_addr),
      .rd_data_ff (cfg)
   );

   // ---------------------------------------------------------------
   // configuration decode
   // ---------------------------------------------------------------
   pldp_op_type  op;
   pldp_src_type src_a;
   pldp_src_type src_b;
   pldp_dst_type dst;
   pldp_fwr_type f0_wr;
   pldp_fwr_type f1_wr;
   logic         f0_ld;
   logic         f1_ld;
   logic         f1_prio;

   // a fresh word every cycle reconfigures the whole slice
   assign op      = pldp_op_type'(cfg[`PLDP_CFG_OP_MSB:`PLDP_CFG_OP_LSB]);
   assign src_a   = pldp_src_type'(cfg[`PLDP_CFG_SRCA_MSB:`PLDP_CFG_SRCA_LSB]);
   assign src_b   = pldp_src_type'(cfg[`PLDP_CFG_SRCB_MSB:`PLDP_CFG_SRCB_LSB]);
   assign dst     = pldp_dst_type'(cfg[`PLDP_CFG_DST_MSB:`PLDP_CFG_DST_LSB]);
   assign f0_ld   = cfg[`PLDP_CFG_F0LD_BIT];
   assign f1_ld   = cfg[`PLDP_CFG_F1LD_BIT];
   assign f0_wr   = pldp_fwr_type'(cfg[`PLDP_CFG_F0WR_MSB:`PLDP_CFG_F0WR_LSB]);
   assign f1_wr   = pldp_fwr_type'(cfg[`PLDP_CFG_F1WR_MSB:`PLDP_CFG_F1WR_LSB]);
   assign f1_prio = cfg[`PLDP_CFG_F1PRIO_BIT];

   // ---------------------------------------------------------------
   // fifos
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] f0_head;
   logic [WIDTH-1:0] f1_head;
   logic             f0_full;
   logic             f0_empty;
   logic             f1_full;
   logic             f1_empty;
   logic             f0_push;
   logic             f1_push;
   logic             f0_pop;
   logic             f1_pop;
   logic [WIDTH-1:0] f0_pdata;
   logic [WIDTH-1:0] f1_pdata;

   pldp_fifo #(
      .DEPTH (FIFO_DEPTH),
      .WIDTH (WIDTH)
   ) u_fifo_zero (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .push      (f0_push),
      .push_data (f0_pdata),
      .pop       (f0_pop),
      .head      (f0_head),
      .full      (f0_full),
      .empty     (f0_empty)
   );

   pldp_fifo #(
      .DEPTH (FIFO_DEPTH),
      .WIDTH (WIDTH)
   ) u_fifo_one (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .push      (f1_push),
      .push_data (f1_pdata),
      .pop       (f1_pop),
      .head      (f1_head),
      .full      (f1_full),
      .empty     (f1_empty)
   );

   // ---------------------------------------------------------------
   // alu
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] opnd_a;
   logic [WIDTH-1:0] opnd_b;
   logic [WIDTH:0]   nxt_alu;

   function automatic logic [WIDTH-1:0] pick(input pldp_src_type s, input logic [WIDTH-1:0] a0,
                                             input logic [WIDTH-1:0] a1, input logic [WIDTH-1:0] d0,
                                             input logic [WIDTH-1:0] d1);
      unique case (s)
         PLDP_SRC_ACC0: pick = a0;
         PLDP_SRC_ACC1: pick = a1;
         PLDP_SRC_DAT0: pick = d0;
         PLDP_SRC_DAT1: pick = d1;
      endcase
   endfunction

   // accumulators and data registers are the operand sources
   assign opnd_a = pick(src_a, accumulator_zero_ff, accumulator_one_ff, data_reg_zero_ff, data_reg_one_ff);
   assign opnd_b = pick(src_b, accumulator_zero_ff, accumulator_one_ff, data_reg_zero_ff, data_reg_one_ff);

   // nine bits wide so add and subtract keep their carry or borrow
   always_comb begin
      nxt_alu = '0;
      unique case (op)
         PLDP_OP_PASS: nxt_alu = {1'b0, opnd_a};
         PLDP_OP_INC:  nxt_alu = {1'b0, opnd_a} + 9'h001;
         PLDP_OP_DEC:  nxt_alu = {1'b0, opnd_a} - 9'h001;
         PLDP_OP_ADD:  nxt_alu = {1'b0, opnd_a} + {1'b0, opnd_b};
         PLDP_OP_SUB:  nxt_alu = {1'b0, opnd_a} - {1'b0, opnd_b};
         PLDP_OP_AND:  nxt_alu = {1'b0, opnd_a & opnd_b};
         PLDP_OP_OR:   nxt_alu = {1'b0, opnd_a | opnd_b};
         PLDP_OP_XOR:  nxt_alu = {1'b0, opnd_a ^ opnd_b};
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         alu_out_ff <= `PLDP_RST_BYTE;
         carry_ff   <= 1'b0;
      end else begin
         alu_out_ff <= nxt_alu[WIDTH-1:0];
         carry_ff   <= nxt_alu[WIDTH];
      end
   end

   // ---------------------------------------------------------------
   // fifo steering
   // ---------------------------------------------------------------
   // bus access has priority over the sequencer on fifo pushes
   function automatic logic [WIDTH-1:0] cap(input pldp_fwr_type w, input logic [WIDTH-1:0] a0,
                                            input logic [WIDTH-1:0] a1, input logic [WIDTH-1:0] r);
      unique case (w)
         PLDP_FWR_NONE: cap = r;
         PLDP_FWR_ACC0: cap = a0;
         PLDP_FWR_ACC1: cap = a1;
         PLDP_FWR_ALU:  cap = r;
      endcase
   endfunction

   assign f0_push  = (bus_wr && bus_sel == 3'h4) || (f0_wr != PLDP_FWR_NONE);
   assign f1_push  = (bus_wr && bus_sel == 3'h5) || (f1_wr != PLDP_FWR_NONE);
   assign f0_pdata = (bus_wr && bus_sel == 3'h4) ? bus_wdata
                   : cap(f0_wr, accumulator_zero_ff, accumulator_one_ff, nxt_alu[WIDTH-1:0]);
   assign f1_pdata = (bus_wr && bus_sel == 3'h5) ? bus_wdata
                   : cap(f1_wr, accumulator_zero_ff, accumulator_one_ff, nxt_alu[WIDTH-1:0]);
   assign f0_pop   = bus_rd_fifo0 || f0_ld;
   assign f1_pop   = bus_rd_fifo1 || f1_ld;

   // ---------------------------------------------------------------
   // accumulators
   // ---------------------------------------------------------------
   // order: bus write, then fifo load, then alu result
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator_zero_ff <= `PLDP_RST_BYTE;
      end else if (bus_wr && bus_sel == 3'h0) begin
         accumulator_zero_ff <= bus_wdata;
      end else if (f0_ld && !f0_empty && !f1_prio) begin
         accumulator_zero_ff <= f0_head;
      end else if (dst == PLDP_DST_ACC0 || dst == PLDP_DST_BOTH) begin
         accumulator_zero_ff <= nxt_alu[WIDTH-1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         accumulator_one_ff <= `PLDP_RST_BYTE;
      end else if (bus_wr && bus_sel == 3'h1) begin
         accumulator_one_ff <= bus_wdata;
      end else if (f1_ld && !f1_empty && !f1_prio) begin
         accumulator_one_ff <= f1_head;
      end else if (dst == PLDP_DST_ACC1 || dst == PLDP_DST_BOTH) begin
         accumulator_one_ff <= nxt_alu[WIDTH-1:0];
      end
   end

   // ---------------------------------------------------------------
   // data registers: never an alu destination
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg_zero_ff <= `PLDP_RST_BYTE;
      end else if (bus_wr && bus_sel == 3'h2) begin
         data_reg_zero_ff <= bus_wdata;
      end else if (f0_ld && !f0_empty && f1_prio) begin
         data_reg_zero_ff <= f0_head;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_reg_one_ff <= `PLDP_RST_BYTE;
      end else if (bus_wr && bus_sel == 3'h3) begin
         data_reg_one_ff <= bus_wdata;
      end else if (f1_ld && !f1_empty && f1_prio) begin
         data_reg_one_ff <= f1_head;
      end
   end

   // ---------------------------------------------------------------
   // compare and condition outputs
   // ---------------------------------------------------------------
   // status is taken from registers one cycle behind their update
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         zero_det0_ff <= 1'b0;
         zero_det1_ff <= 1'b0;
         ff_det0_ff   <= 1'b0;
         ff_det1_ff   <= 1'b0;
         eq_cmp0_ff   <= 1'b0;
         lt_cmp0_ff   <= 1'b0;
         eq_cmp1_ff   <= 1'b0;
         lt_cmp1_ff   <= 1'b0;
      end else begin
         zero_det0_ff <= (accumulator_zero_ff == '0);
         zero_det1_ff <= (accumulator_one_ff == '0);
         ff_det0_ff   <= (accumulator_zero_ff == '1);
         ff_det1_ff   <= (accumulator_one_ff == '1);
         eq_cmp0_ff   <= (accumulator_zero_ff == data_reg_zero_ff);
         lt_cmp0_ff   <= (accumulator_zero_ff < data_reg_zero_ff);
         eq_cmp1_ff   <= (accumulator_one_ff == data_reg_one_ff);
         lt_cmp1_ff   <= (accumulator_one_ff < data_reg_one_ff);
      end
   end

   // ---------------------------------------------------------------
   // registered fifo views
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifo_zero_head_ff  <= `PLDP_RST_BYTE;
         fifo_one_head_ff   <= `PLDP_RST_BYTE;
         fifo_zero_full_ff  <= 1'b0;
         fifo_zero_empty_ff <= 1'b1;
         fifo_one_full_ff   <= 1'b0;
         fifo_one_empty_ff  <= 1'b1;
      end else begin
         fifo_zero_head_ff  <= f0_head;
         fifo_one_head_ff   <= f1_head;
         fifo_zero_full_ff  <= f0_full;
         fifo_zero_empty_ff <= f0_empty;
         fifo_one_full_ff   <= f1_full;
         fifo_one_empty_ff  <= f1_empty;
      end
   end
endmodule
`default_nettype wire

// *** verilog/pldp_defines.svh ***
// constants for the programmable logic block datapath
`ifndef PLDP_DEFINES_SVH
`define PLDP_DEFINES_SVH

// ---------------------------------------------------------------
// configuration word fields
// ---------------------------------------------------------------
`define PLDP_CFG_OP_LSB      0
`define PLDP_CFG_OP_MSB      2
`define PLDP_CFG_SRCA_LSB    3
`define PLDP_CFG_SRCA_MSB    4
`define PLDP_CFG_SRCB_LSB    5
`define PLDP_CFG_SRCB_MSB    6
`define PLDP_CFG_DST_LSB     7
`define PLDP_CFG_DST_MSB     8
`define PLDP_CFG_F0LD_BIT    9
`define PLDP_CFG_F1LD_BIT    10
`define PLDP_CFG_F0WR_LSB    11
`define PLDP_CFG_F0WR_MSB    12
`define PLDP_CFG_F1WR_LSB    13
`define PLDP_CFG_F1WR_MSB    14
`define PLDP_CFG_F1PRIO_BIT  15

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PLDP_RST_BYTE        8'h00
`define PLDP_RST_CFG         16'h0000

`endif

// *** verilog/pldp_fifo.sv ***
// small byte fifo used as the datapath bus interface
`default_nettype none
module pldp_fifo
   import pldp_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int WIDTH = 8
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // fill side
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   // drain side
   input  wire logic             pop,
   output logic      [WIDTH-1:0] head,
   // status
   output logic                  full,
   output logic                  empty
);
   localparam int PW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || DEPTH != (1 << PW)) begin
         $error("pldp_fifo: DEPTH must be a power of two, at least 2");
      end
   end

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [PW:0]      count_ff;
   logic             do_push;
   logic             do_pop;

   // overflow and underflow are dropped rather than corrupting state
   assign do_pop  = pop && (count_ff != '0);
   assign do_push = push && ((count_ff != (PW+1)'(DEPTH)) || do_pop);
   assign full    = (count_ff == (PW+1)'(DEPTH));
   assign empty   = (count_ff == '0);
   assign head    = mem_ff[rd_ptr_ff];

   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= push_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + PW'(1);
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + PW'(1);
         end
         count_ff <= count_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
endmodule
`default_nettype wire

// *** verilog/pldp_pkg.sv ***
// types shared by the programmable logic block datapath
`default_nettype none
package pldp_pkg;
   typedef enum logic [2:0] {
      PLDP_OP_PASS = 3'h0,
      PLDP_OP_INC  = 3'h1,
      PLDP_OP_DEC  = 3'h2,
      PLDP_OP_ADD  = 3'h3,
      PLDP_OP_SUB  = 3'h4,
      PLDP_OP_AND  = 3'h5,
      PLDP_OP_OR   = 3'h6,
      PLDP_OP_XOR  = 3'h7
   } pldp_op_type;

   // operand sources
   typedef enum logic [1:0] {
      PLDP_SRC_ACC0 = 2'h0,
      PLDP_SRC_ACC1 = 2'h1,
      PLDP_SRC_DAT0 = 2'h2,
      PLDP_SRC_DAT1 = 2'h3
   } pldp_src_type;

   // result destination
   typedef enum logic [1:0] {
      PLDP_DST_NONE = 2'h0,
      PLDP_DST_ACC0 = 2'h1,
      PLDP_DST_ACC1 = 2'h2,
      PLDP_DST_BOTH = 2'h3
   } pldp_dst_type;

   // fifo capture selection
   typedef enum logic [1:0] {
      PLDP_FWR_NONE = 2'h0,
      PLDP_FWR_ACC0 = 2'h1,
      PLDP_FWR_ACC1 = 2'h2,
      PLDP_FWR_ALU  = 2'h3
   } pldp_fwr_type;
endpackage
`default_nettype wire
